//--- verilog/pwft_pkg.sv
// constants, types and helpers shared by the pwm frequency and edge timing block
`default_nettype none

package pwft_pkg;

    localparam int REG_W      = 8;
    localparam int CODE_W     = 6;
    localparam int EDGE_W     = 12;
    localparam int EDGE_HI_W  = 8;
    localparam int EDGE_LO_W  = 4;
    localparam int IDX_W      = 8;
    localparam int TICK_W     = 13;
    localparam int ADDR_IDX_LSB = 2;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_FREQ_SEL = 8'h40;
    localparam logic [IDX_W-1:0] IDX_EDGE_HI  = 8'h41;
    localparam logic [IDX_W-1:0] IDX_EDGE_SET = 8'h42;
    localparam logic [IDX_W-1:0] IDX_STATUS   = 8'h50;

    // field positions
    localparam int FREQ_CODE_LSB = 0;
    localparam int FREQ_RSVD_LSB = 6;
    localparam int FREQ_RSVD_W   = 2;
    localparam int EDGE_LO_LSB   = 4;
    localparam int MOD_EN_BIT    = 3;
    localparam int SIGN_BIT      = 2;
    localparam int SET_RSVD_LSB  = 0;
    localparam int SET_RSVD_W    = 2;
    localparam int STS_RESONANT_BIT = 0;
    localparam int STS_UNDEF_BIT    = 1;
    localparam int STS_RSVD_BIT     = 2;
    localparam int STS_RUN_BIT      = 3;
    localparam int STS_EDGE_LSB     = 16;

    // reset values
    localparam logic [REG_W-1:0] RST_FREQ_SEL = 8'h00;
    localparam logic [REG_W-1:0] RST_EDGE_HI  = 8'h00;
    localparam logic [REG_W-1:0] RST_EDGE_SET = 8'h00;

    // frequency codes
    localparam logic [CODE_W-1:0] CODE_RESONANT    = 6'h3F;
    localparam logic [CODE_W-1:0] CODE_MAX_DEFINED = 6'h36;

    // timing: edge step and clock period in picoseconds
    localparam int STEP_PS       = 5000;
    localparam int CLK_PERIOD_PS = 20000;
    localparam int TICKS_PER_CLK = CLK_PERIOD_PS / STEP_PS;
    localparam int OCT_SLOTS     = 32;
    localparam int TOP_SHIFT     = 7;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    typedef struct packed {
        logic             valid;
        logic             write;
        logic [IDX_W-1:0] idx;
    } pwft_bus_req_t;

    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic [EDGE_W-1:0] edge_time;
        logic              mod_en;
        logic              sign;
    } pwft_cfg_t;

    typedef enum logic [1:0] {
        ST_HALT = 2'b01,
        ST_RUN  = 2'b10
    } pwft_state_t;

    // period in 5 ns steps: 32 slots per octave, each octave halves the step;
    // the top octave moves two slots per code, so it ends at 20 slots
    function automatic logic [TICK_W-1:0] pwft_period_ticks(input logic [CODE_W-1:0] code);
        logic [CODE_W-1:0] c;
        logic [5:0]        slots;
        logic [5:0]        dec;
        c = (code > CODE_MAX_DEFINED) ? CODE_MAX_DEFINED : code;
        dec = (&c[5:4]) ? {1'b0, c[3:0], 1'b0} : {2'h0, c[3:0]};
        slots = 6'(OCT_SLOTS) - dec;
        pwft_period_ticks = TICK_W'({7'h00, slots} << (TOP_SHIFT - int'(c[5:4])));
    endfunction : pwft_period_ticks

    function automatic logic pwft_hit(input logic [TICK_W-1:0] cnt,
                                      input logic [EDGE_W-1:0] t);
        pwft_hit = ({1'b0, t} >= cnt) && ({1'b0, t} < cnt + TICK_W'(TICKS_PER_CLK));
    endfunction : pwft_hit

endpackage : pwft_pkg

`default_nettype wire

//--- verilog/pwft_period_gen.sv
// period counter in 5 ns steps that marks period starts and the first edge
`timescale 1ns/1ps
`default_nettype none

module pwft_period_gen
    import pwft_pkg::*;
(
    input  wire logic      hclk,
    input  wire logic      hresetn,
    input  wire logic      ce,
    input  wire pwft_cfg_t cfg,
    output var  logic      wrap,
    output var  logic      period_start_r,
    output var  logic      edge_strobe_r,
    output var  logic      running_r
);

    pwft_state_t       state_r;
    pwft_state_t       state_nxt;
    logic [TICK_W-1:0] cnt_r;
    logic [TICK_W-1:0] cnt_nxt;
    logic [TICK_W-1:0] period;
    logic              start_nxt;
    logic              strobe_nxt;

    assign period = pwft_period_ticks(cfg.code);

    always_comb begin
        state_nxt  = state_r;
        cnt_nxt    = cnt_r;
        start_nxt  = 1'b0;
        strobe_nxt = 1'b0;
        wrap       = 1'b0;
        unique case (state_r)
            ST_HALT: begin
                // resonant mode: no fixed period
                cnt_nxt = '0;
                if (cfg.code != CODE_RESONANT) begin
                    state_nxt = ST_RUN;
                    start_nxt = 1'b1;
                end
            end
            ST_RUN: begin
                if (cfg.code == CODE_RESONANT) begin
                    // stop at once, no fixed-period strobes while resonant
                    state_nxt = ST_HALT;
                    cnt_nxt   = '0;
                end else begin
                    // edge placed to 5 ns within the 20 ns clock slot
                    strobe_nxt = pwft_hit(cnt_r, cfg.edge_time);
                    if (cnt_r + TICK_W'(TICKS_PER_CLK) >= period) begin
                        cnt_nxt   = '0;
                        wrap      = 1'b1;
                        start_nxt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + TICK_W'(TICKS_PER_CLK);
                    end
                end
            end
            default: begin
                state_nxt = ST_HALT;
                cnt_nxt   = '0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r        <= ST_HALT;
            cnt_r          <= '0;
            period_start_r <= 1'b0;
            edge_strobe_r  <= 1'b0;
            running_r      <= 1'b0;
        end else if (ce) begin
            state_r        <= state_nxt;
            cnt_r          <= cnt_nxt;
            period_start_r <= start_nxt;
            edge_strobe_r  <= strobe_nxt;
            running_r      <= (state_nxt == ST_RUN);
        end
    end

endmodule : pwft_period_gen

`default_nettype wire

//--- verilog/pwft_top.sv
// ahb-lite register block and period timing for the main pwm outputs
//
// Behaviour
// - 6-bit frequency code, 48.8 kHz up to 625 kHz; all ones selects resonant mode.
// - 8-bit register holds the upper eight bits of the 12-bit first-edge time.
// - first-edge time is always the high byte joined with the companion nibble.
// - each first-edge unit is one 5 ns step.
// - low four first-edge bits live in bits 7:4 of the companion register.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pwft_top
    import pwft_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              ce,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output var  logic [31:0]       hrdata,
    output var  logic              hreadyout,
    output var  logic              hresp,
    output var  logic              main_period_start,
    output var  logic              first_edge_strobe,
    output var  logic [EDGE_W-1:0] first_edge_time,
    output var  logic              first_edge_modulate_en,
    output var  logic              first_edge_sign,
    output var  logic              resonant_mode
);

    // bus state
    pwft_bus_req_t    req_r;
    pwft_bus_req_t    req_nxt;
    logic [31:0]      rdata_r;
    logic [31:0]      rdata_nxt;

    // software registers
    logic [REG_W-1:0] freq_sel_r;
    logic [REG_W-1:0] freq_sel_nxt;
    logic [REG_W-1:0] edge_hi_r;
    logic [REG_W-1:0] edge_hi_nxt;
    logic [REG_W-1:0] edge_set_r;
    logic [REG_W-1:0] edge_set_nxt;
    logic             undef_r;
    logic             undef_nxt;
    logic             rsvd_r;
    logic             rsvd_nxt;

    // configuration in force for the running period
    pwft_cfg_t        active_r;
    pwft_cfg_t        active_nxt;
    pwft_cfg_t        staged;
    logic             resonant_r;
    logic             resonant_nxt;

    logic             wr_en;
    logic             wr_freq;
    logic             wr_hi;
    logic             wr_set;
    logic             wr_sts;
    logic [REG_W-1:0] wbyte;
    logic             gen_wrap;
    logic             gen_running;

    if (TICKS_PER_CLK < 1 || CLK_PERIOD_PS % STEP_PS != 0) begin : g_bad_step
        $error("clock period must be a whole number of edge steps");
    end
    if (EDGE_HI_W + EDGE_LO_W != EDGE_W) begin : g_bad_edge
        $error("edge time halves must add to the full width");
    end

    function automatic logic pwft_is_idx(input pwft_bus_req_t r,
                                         input logic [IDX_W-1:0] idx);
        pwft_is_idx = r.valid && (r.idx == idx);
    endfunction : pwft_is_idx

    function automatic logic [31:0] pwft_read(input logic [IDX_W-1:0] idx,
                                              input logic [REG_W-1:0] fs,
                                              input logic [REG_W-1:0] hi,
                                              input logic [REG_W-1:0] st,
                                              input logic [31:0]      sts);
        logic [31:0] d;
        d = '0;
        unique case (idx)
            IDX_FREQ_SEL: d[REG_W-1:0] = fs;
            IDX_EDGE_HI:  d[REG_W-1:0] = hi;
            IDX_EDGE_SET: d[REG_W-1:0] = st;
            IDX_STATUS:   d = sts;
            default:      d = '0;
        endcase
        pwft_read = d;
    endfunction : pwft_read

    // address phase capture and data phase write decode
    always_comb begin
        req_nxt.valid = hsel && hready && (htrans == HTRANS_NONSEQ);
        req_nxt.write = hwrite;
        req_nxt.idx   = haddr[ADDR_IDX_LSB +: IDX_W];
        if (!req_nxt.valid) begin
            req_nxt.write = 1'b0;
            req_nxt.idx   = '0;
        end
        if (|haddr[31:ADDR_IDX_LSB+IDX_W]) begin
            req_nxt.idx = '1;
        end
    end

    assign wr_en   = req_r.valid && req_r.write;
    assign wbyte   = hwdata[REG_W-1:0];
    assign wr_freq = wr_en && pwft_is_idx(req_r, IDX_FREQ_SEL);
    assign wr_hi   = wr_en && pwft_is_idx(req_r, IDX_EDGE_HI);
    assign wr_set  = wr_en && pwft_is_idx(req_r, IDX_EDGE_SET);
    assign wr_sts  = wr_en && pwft_is_idx(req_r, IDX_STATUS);

    // register writes and sticky flags
    always_comb begin
        freq_sel_nxt = freq_sel_r;
        edge_hi_nxt  = edge_hi_r;
        edge_set_nxt = edge_set_r;
        undef_nxt    = undef_r;
        rsvd_nxt     = rsvd_r;
        if (wr_freq) begin
            freq_sel_nxt = wbyte;
        end
        if (wr_hi) begin
            edge_hi_nxt = wbyte;
        end
        if (wr_set) begin
            edge_set_nxt = wbyte;
        end
        // write one to clear; a new event in the same cycle still sets
        if (wr_sts && wbyte[STS_UNDEF_BIT]) begin
            undef_nxt = 1'b0;
        end
        if (wr_sts && wbyte[STS_RSVD_BIT]) begin
            rsvd_nxt = 1'b0;
        end
        // flags record software breaking its side of the contract
        if (wr_freq && wbyte[CODE_W-1:0] > CODE_MAX_DEFINED
                    && wbyte[CODE_W-1:0] != CODE_RESONANT) begin
            undef_nxt = 1'b1;
        end
        if ((wr_freq && |wbyte[FREQ_RSVD_LSB +: FREQ_RSVD_W])
            || (wr_set && |wbyte[SET_RSVD_LSB +: SET_RSVD_W])) begin
            rsvd_nxt = 1'b1;
        end
    end

    // read data, with the write being committed this cycle forwarded
    always_comb begin
        logic [REG_W-1:0] fs;
        logic [REG_W-1:0] hi;
        logic [REG_W-1:0] st;
        logic [31:0]      sts;
        fs  = freq_sel_nxt;
        hi  = edge_hi_nxt;
        st  = edge_set_nxt;
        sts = '0;
        sts[STS_RESONANT_BIT]          = resonant_r;
        sts[STS_UNDEF_BIT]             = undef_nxt;
        sts[STS_RSVD_BIT]              = rsvd_nxt;
        sts[STS_RUN_BIT]               = gen_running;
        sts[STS_EDGE_LSB +: EDGE_W]    = active_r.edge_time;
        rdata_nxt = rdata_r;
        if (req_nxt.valid && !req_nxt.write) begin
            rdata_nxt = pwft_read(req_nxt.idx, fs, hi, st, sts);
        end
    end

    // staged settings are taken only at a period boundary or while the counter is halted so a period never
    // mixes old and new timing; the edge time is never split across halves
    always_comb begin
        staged.code      = freq_sel_r[FREQ_CODE_LSB +: CODE_W];
        staged.edge_time = {edge_hi_r, edge_set_r[EDGE_LO_LSB +: EDGE_LO_W]};
        staged.mod_en    = edge_set_r[MOD_EN_BIT];
        staged.sign      = edge_set_r[SIGN_BIT];
        active_nxt       = active_r;
        if (gen_wrap || !gen_running) begin
            active_nxt = staged;
        end
        resonant_nxt = (active_nxt.code == CODE_RESONANT);
    end

    // bus side keeps answering while ce is low so no transfer is lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r      <= '0;
            rdata_r    <= '0;
            freq_sel_r <= RST_FREQ_SEL;
            edge_hi_r  <= RST_EDGE_HI;
            edge_set_r <= RST_EDGE_SET;
            undef_r    <= 1'b0;
            rsvd_r     <= 1'b0;
        end else begin
            req_r      <= req_nxt;
            rdata_r    <= rdata_nxt;
            freq_sel_r <= freq_sel_nxt;
            edge_hi_r  <= edge_hi_nxt;
            edge_set_r <= edge_set_nxt;
            undef_r    <= undef_nxt;
            rsvd_r     <= rsvd_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_r   <= '{code: RST_FREQ_SEL[CODE_W-1:0],
                            edge_time: '0, mod_en: 1'b0, sign: 1'b0};
            resonant_r <= 1'b0;
        end else if (ce) begin
            active_r   <= active_nxt;
            resonant_r <= resonant_nxt;
        end
    end

    // auxiliary output period is elsewhere; this counter feeds main outputs only
    pwft_period_gen u_gen (
        .hclk           (hclk),
        .hresetn        (hresetn),
        .ce             (ce),
        .cfg            (active_r),
        .wrap           (gen_wrap),
        .period_start_r (main_period_start),
        .edge_strobe_r  (first_edge_strobe),
        .running_r      (gen_running)
    );

    assign hrdata                 = rdata_r;
    assign hreadyout              = 1'b1;
    assign hresp                  = HRESP_OKAY;
    assign first_edge_time        = active_r.edge_time;
    assign first_edge_modulate_en = active_r.mod_en;
    assign first_edge_sign        = active_r.sign;
    assign resonant_mode          = resonant_r;

endmodule : pwft_top

`default_nettype wire

//--- dv/pwft_monitor.sv
// assertion checker for the pwm frequency and edge timing block
`timescale 1ns/1ps
`default_nettype none

module pwft_monitor
    import pwft_pkg::*;
(
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic              main_period_start,
    input wire logic              first_edge_strobe,
    input wire logic [EDGE_W-1:0] first_edge_time,
    input wire logic              first_edge_modulate_en,
    input wire logic              first_edge_sign,
    input wire logic              resonant_mode
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence rd_take;
        hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    endsequence
    // shortest legal period is 80 cycles
    sequence restart;
        main_period_start ##[1:79] main_period_start;
    endsequence

    a_ready_ok: assert property (
        hreadyout && hresp == HRESP_OKAY) else $error("bus answer not ready or not okay");
    a_rd_stable: assert property (
        !(hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_period_min: assert property (
        not (!resonant_mode throughout restart)) else $error("period shorter than 80 cycles");
    a_first_start: assert property (
        $rose(hresetn) |-> ##[0:2] main_period_start) else $error("no period after reset");
    a_res_quiet: assert property (
        resonant_mode && $past(resonant_mode) |-> !main_period_start && !first_edge_strobe)
        else $error("strobe while resonant");
    a_res_exit: assert property (
        $fell(resonant_mode) |-> ##[0:2] main_period_start) else $error("no period on exit");
    a_edge_whole: assert property (
        $changed({first_edge_time, first_edge_modulate_en, first_edge_sign})
        |-> main_period_start || $past(main_period_start) || $past(resonant_mode))
        else $error("edge setting changed mid period");
    a_edge_once: assert property (
        first_edge_strobe |=> !first_edge_strobe [*3]) else $error("edge strobe repeated");
    c_read: cover property (rd_take);
endmodule : pwft_monitor

bind pwft_top pwft_monitor mon_u (.*);

`default_nettype wire

//--- dv/testbench.sv
// self-checking testbench for the pwm frequency and edge timing block
`timescale 1ns/1ps
`default_nettype none

module testbench
    import pwft_pkg::*;
;
    logic              hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0]       haddr, hwdata, hrdata;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic              main_period_start, first_edge_strobe, resonant_mode;
    logic              first_edge_modulate_en, first_edge_sign;
    logic [EDGE_W-1:0] first_edge_time;
    logic [31:0]       rd_q[$], per_q[$], edg_q[$];
    logic [5:0]        codes[5] = '{6'h00, 6'h0F, 6'h10, 6'h25, 6'h36};
    logic [11:0]       t;
    logic [1:0]        ms;
    logic              rd_dph = 1'b0;
    int                n_errors, num_checks, cnt, c0;

    assign hready = hreadyout;

    pwft_top dut_u (.*);

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk

    task automatic print_verdict;
        if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    // read expectation travels in d; bus waits on hready, never a fixed count
    task automatic bus(logic w, logic [IDX_W-1:0] idx, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {22'h0, idx, 2'h0};
        do @(posedge hclk); while (hready !== 1'b1);
        if (!w) rd_q.push_back(d);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask : bus

    task automatic wait_start;
        do @(posedge hclk); while (main_period_start !== 1'b1);
    endtask : wait_start

    // top octave moves two slots per code
    function automatic int exp_per(logic [5:0] c);
        int step;
        step = (c[5:4] == 2'h3) ? 2 : 1;
        return ((32 - step * int'(c[3:0])) << (7 - int'(c[5:4]))) / 4;
    endfunction : exp_per

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        if (rd_dph && rd_q.size() > 0) chk("hrdata", rd_q.pop_front(), hrdata);
        rd_dph <= hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
        if (main_period_start) begin
            if (per_q.size() > 0) chk("period", per_q.pop_front(), cnt);
            cnt <= 1;
        end else begin
            cnt <= cnt + 1;
        end
        if (first_edge_strobe && edg_q.size() > 0) chk("edge", edg_q.pop_front(),
            {first_edge_time, first_edge_modulate_en, first_edge_sign, 2'h0, 16'(cnt)});
    end

    initial begin
        repeat (60000) @(posedge hclk);
        n_errors++;
        print_verdict();
    end

    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        ce = 1'b1;
        hsize = 3'h2;
        void'($urandom(2610));
        codes[3] = 6'($urandom_range(0, 54));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, IDX_FREQ_SEL, 32'h0);
        bus(1'b0, IDX_EDGE_HI, 32'h0);
        bus(1'b0, IDX_EDGE_SET, 32'h0);
        bus(1'b1, 8'h60, 32'hFF);
        bus(1'b0, 8'h60, 32'h0);
        foreach (codes[i]) begin
            bus(1'b1, IDX_FREQ_SEL, {26'h0, codes[i]});
            bus(1'b0, IDX_FREQ_SEL, {26'h0, codes[i]});
            wait_start();
            wait_start();
            @(negedge hclk);
            per_q.push_back(exp_per(codes[i]));
            wait_start();
        end
        bus(1'b1, IDX_FREQ_SEL, 32'h0);
        // code 0 is the longest period, so any time from 4 up lands inside it
        t = 12'($urandom_range(4, 4095));
        ms = 2'($urandom);
        bus(1'b1, IDX_EDGE_HI, {24'h0, t[11:4]});
        bus(1'b1, IDX_EDGE_SET, {24'h0, t[3:0], ms, 2'h0});
        bus(1'b0, IDX_EDGE_HI, {24'h0, t[11:4]});
        bus(1'b0, IDX_EDGE_SET, {24'h0, t[3:0], ms, 2'h0});
        wait_start();
        wait_start();
        @(negedge hclk);
        // strobe shows one cycle after its slot; the bench count starts at one
        edg_q.push_back({t, ms, 2'h0, 16'(t >> 2) + 16'h1});
        wait_start();
        @(posedge hclk);
        bus(1'b1, IDX_FREQ_SEL, {26'h0, CODE_RESONANT});
        wait_start();
        repeat (300) @(posedge hclk);
        chk("resonant", 32'h1, {31'h0, resonant_mode});
        bus(1'b1, IDX_FREQ_SEL, 32'h36);
        repeat (300) @(posedge hclk);
        chk("resonant", 32'h0, {31'h0, resonant_mode});
        // ce low must hold the period counter, so no start may come
        wait_start();
        ce <= 1'b0;
        repeat (2) @(posedge hclk);
        c0 = cnt;
        repeat (200) @(posedge hclk);
        chk("frozen", c0 + 200, cnt);
        ce <= 1'b1;
        chk("rd_left", 32'h0, rd_q.size());
        chk("per_left", 32'h0, per_q.size());
        chk("edge_left", 32'h0, edg_q.size());
        print_verdict();
    end
endmodule : testbench

`default_nettype wire
